/* rtl/pcr_defines.vh */
// What this block does
// - Each element is flip-flop or latch
// - One shared clock, separate clock enables
// - Shared set/reset, four modes per element
// - Buffers and controls each have inversion
// - Unused drivers high-impedance before configuration
// - Pull-down and keeper off before configuration
// - Mode pin picks pre-configuration pull-ups globally
// - Input path direct or through register
// - Optional matched delay before input register
// - Configured pull-up and pull-down after configuration
// - Output and enable direct or registered
// - Keeper drives pin to sensed level
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

// Register bus geometry
`define PCR_AW          8
`define PCR_DW          32

// Register byte addresses
`define PCR_ADDR_CTRL   8'h00
`define PCR_ADDR_ELEM   8'h04
`define PCR_ADDR_INV    8'h08
`define PCR_ADDR_PAD    8'h0C
`define PCR_ADDR_STAT   8'h10

// Element indices
`define PCR_EL_IN       0
`define PCR_EL_OUT      1
`define PCR_EL_TRI      2
`define PCR_NEL         3

// Per-element config nibble
`define PCR_EF_W        4
`define PCR_EF_LATCH    0
`define PCR_EF_SR_LO    1
`define PCR_EF_SR_HI    2
`define PCR_EF_REG      3

// Shared set/reset modes
`define PCR_SR_SSET     2'h0
`define PCR_SR_SRST     2'h1
`define PCR_SR_APRE     2'h2
`define PCR_SR_ACLR     2'h3

// Inversion register fields
`define PCR_INV_IBUF    0
`define PCR_INV_OBUF    1
`define PCR_INV_CLK     2
`define PCR_INV_SR      3
`define PCR_INV_CE_LO   4
`define PCR_INV_CE_HI   6

// Pad register fields
`define PCR_PAD_PU      0
`define PCR_PAD_PD      1
`define PCR_PAD_KEEP    2
`define PCR_PAD_DLY     3

// Control and status fields
`define PCR_CTRL_DONE   0
`define PCR_ST_Q_LO     0
`define PCR_ST_Q_HI     2
`define PCR_ST_PAD      3
`define PCR_ST_DONE     4

// Reset values
`define PCR_ELEM_RST    12'h000
`define PCR_INV_RST     7'h00
`define PCR_PAD_RST     4'h0

// Matched clock-distribution delay, in system clock cycles
`define PCR_DLY_CYC     2

`endif

/* rtl/pcr_store.v */
`timescale 1ns/100ps
`include "pcr_defines.vh"

module pcr_store (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       ena,
  // Configuration
  input  wire       latch_mode,
  input  wire [1:0] sr_mode,
  // Controls, polarity already applied
  input  wire       clk_lvl,
  input  wire       clk_rise,
  input  wire       ce,
  input  wire       sr,
  input  wire       d,
  // State
  output reg        q_q
);

  wire sr_async = sr_mode[1];
  wire sr_val   = (sr_mode == `PCR_SR_SSET) || (sr_mode == `PCR_SR_APRE);
  // Latch is open while clock level active, flop takes rising edge only
  wire open_now = latch_mode ? (clk_lvl && ce) : (clk_rise && ce);

  ////////////////////////////////////////////////////////////////////
  // Storage element
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= 1'b0;
    end else if (ena) begin
      if (sr && sr_async) begin
        q_q <= sr_val;
      end else if (open_now) begin
        q_q <= sr ? sr_val : d;
      end
    end
  end

endmodule // pcr_store

/* rtl/pcr_delay.v */
`timescale 1ns/100ps
`include "pcr_defines.vh"

module pcr_delay (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst_n,
  input  wire ena,
  // Data
  input  wire d,
  output wire q
);

  reg [`PCR_DLY_CYC-1:0] stg_q;

  ////////////////////////////////////////////////////////////////////
  // Delay chain, one flop per stage
  genvar i;
  generate
    for (i = 0; i < `PCR_DLY_CYC; i = i + 1) begin : g_stg
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stg_q[i] <= 1'b0;
        end else if (ena) begin
          stg_q[i] <= (i == 0) ? d : stg_q[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  assign q = stg_q[`PCR_DLY_CYC-1];

endmodule // pcr_delay

/* rtl/pcr_pad_cell.v */
`timescale 1ns/100ps
`include "pcr_defines.vh"

module pcr_pad_cell (
  // Clock, reset, enable
  input  wire                sys_clk,
  input  wire                nrst,
  input  wire                sys_ce,
  // Register port
  input  wire [`PCR_AW-1:0]  reg_addr,
  input  wire [`PCR_DW-1:0]  reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [`PCR_DW-1:0]  reg_rdata_q,
  // Configuration mode pin
  input  wire                boot_pullup,
  // User logic side
  input  wire                user_clk,
  input  wire [2:0]          user_ce,
  input  wire                user_sr,
  input  wire                user_out,
  input  wire                user_tri,
  output reg                 user_in_q,
  // Pad side
  input  wire                pad_i,
  output reg                 pad_o_q,
  output reg                 pad_oe_q,
  output reg                 pull_up_q,
  output reg                 pull_down_q,
  output reg                 keep_o_q,
  output reg                 keep_oe_q
);

  ////////////////////////////////////////////////////////////////////
  // Reset release
  reg                        rst_s1_q;
  reg                        rst_n;

  // Async assert, two-flop release
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration registers
  reg                        done_q;
  reg  [3*`PCR_EF_W-1:0]     elem_q;
  reg  [6:0]                 inv_q;
  reg  [3:0]                 pad_cfg_q;
  wire [`PCR_NEL-1:0]        q_el;

  // Writes; done stays until reset so configuration is one-way
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q    <= 1'b0;
      elem_q    <= `PCR_ELEM_RST;
      inv_q     <= `PCR_INV_RST;
      pad_cfg_q <= `PCR_PAD_RST;
    end else if (sys_ce && reg_wr) begin
      if (reg_addr == `PCR_ADDR_CTRL) begin
        done_q <= done_q | reg_wdata[`PCR_CTRL_DONE];
      end else if (reg_addr == `PCR_ADDR_ELEM) begin
        elem_q <= reg_wdata[3*`PCR_EF_W-1:0];
      end else if (reg_addr == `PCR_ADDR_INV) begin
        inv_q <= reg_wdata[`PCR_INV_CE_HI:0];
      end else if (reg_addr == `PCR_ADDR_PAD) begin
        pad_cfg_q <= reg_wdata[`PCR_PAD_DLY:0];
      end
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= {`PCR_DW{1'b0}};
    end else if (sys_ce) begin
      reg_rdata_q <= {`PCR_DW{1'b0}};
      if (reg_rd) begin
        if (reg_addr == `PCR_ADDR_CTRL) begin
          reg_rdata_q[`PCR_CTRL_DONE] <= done_q;
        end else if (reg_addr == `PCR_ADDR_ELEM) begin
          reg_rdata_q[3*`PCR_EF_W-1:0] <= elem_q;
        end else if (reg_addr == `PCR_ADDR_INV) begin
          reg_rdata_q[`PCR_INV_CE_HI:0] <= inv_q;
        end else if (reg_addr == `PCR_ADDR_PAD) begin
          reg_rdata_q[`PCR_PAD_DLY:0] <= pad_cfg_q;
        end else if (reg_addr == `PCR_ADDR_STAT) begin
          reg_rdata_q[`PCR_ST_Q_HI:`PCR_ST_Q_LO] <= q_el;
          reg_rdata_q[`PCR_ST_PAD]               <= pad_i;
          reg_rdata_q[`PCR_ST_DONE]              <= done_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control polarity and clock edge
  reg                        clk_prev_q;
  wire                       clk_lvl  = user_clk ^ inv_q[`PCR_INV_CLK];
  wire                       clk_rise = clk_lvl & ~clk_prev_q;
  wire                       sr_lvl   = user_sr ^ inv_q[`PCR_INV_SR];
  wire [2:0]                 ce_lvl   = user_ce ^ inv_q[`PCR_INV_CE_HI:`PCR_INV_CE_LO];

  // Previous clock level for edge detection
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
    end else if (sys_ce) begin
      clk_prev_q <= clk_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Input buffer and delay stage
  wire                       ibuf = pad_i ^ inv_q[`PCR_INV_IBUF];
  wire                       ibuf_dly;
  wire                       in_d;

  pcr_delay u_delay (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ena     (sys_ce),
    .d       (ibuf),
    .q       (ibuf_dly)
  );

  // Delay only when configured, matched to clock distribution
  assign in_d = pad_cfg_q[`PCR_PAD_DLY] ? ibuf_dly : ibuf;

  ////////////////////////////////////////////////////////////////////
  // Three storage elements, shared clock and set/reset
  wire [`PCR_NEL-1:0]        d_el = {user_tri, user_out, in_d};

  genvar e;
  generate
    for (e = 0; e < `PCR_NEL; e = e + 1) begin : g_el
      pcr_store u_store (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .ena        (sys_ce),
        .latch_mode (elem_q[e*`PCR_EF_W+`PCR_EF_LATCH]),
        .sr_mode    (elem_q[e*`PCR_EF_W+`PCR_EF_SR_HI:e*`PCR_EF_W+`PCR_EF_SR_LO]),
        .clk_lvl    (clk_lvl),
        .clk_rise   (clk_rise),
        .ce         (ce_lvl[e]),
        .sr         (sr_lvl),
        .d          (d_el[e]),
        .q_q        (q_el[e])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Route selection
  wire in_reg  = elem_q[`PCR_EL_IN*`PCR_EF_W+`PCR_EF_REG];
  wire out_reg = elem_q[`PCR_EL_OUT*`PCR_EF_W+`PCR_EF_REG];
  wire tri_reg = elem_q[`PCR_EL_TRI*`PCR_EF_W+`PCR_EF_REG];
  wire in_sel  = in_reg ? q_el[`PCR_EL_IN] : ibuf;
  wire out_sel = out_reg ? q_el[`PCR_EL_OUT] : user_out;
  wire tri_sel = tri_reg ? q_el[`PCR_EL_TRI] : user_tri;
  // Driver on only after configuration and with three-state released
  wire oe_d    = done_q & ~tri_sel;

  ////////////////////////////////////////////////////////////////////
  // Pad outputs, all registered
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_in_q   <= 1'b0;
      pad_o_q     <= 1'b0;
      pad_oe_q    <= 1'b0;
      pull_up_q   <= 1'b0;
      pull_down_q <= 1'b0;
      keep_o_q    <= 1'b0;
      keep_oe_q   <= 1'b0;
    end else if (sys_ce) begin
      user_in_q <= in_sel;
      pad_o_q   <= out_sel ^ inv_q[`PCR_INV_OBUF];
      pad_oe_q  <= oe_d;
      if (!done_q) begin
        pull_up_q   <= boot_pullup;
        pull_down_q <= 1'b0;
        keep_oe_q   <= 1'b0;
      end else begin
        pull_up_q   <= pad_cfg_q[`PCR_PAD_PU];
        pull_down_q <= pad_cfg_q[`PCR_PAD_PD];
        // Keeper yields while the main driver is on
        keep_oe_q   <= pad_cfg_q[`PCR_PAD_KEEP] & ~oe_d;
      end
      keep_o_q <= pad_i;
    end
  end

endmodule // pcr_pad_cell

/* bench/pcr_pad_cell_monitor.sv */
`timescale 1ns/100ps
`include "pcr_defines.vh"
module pcr_pad_cell_monitor (
  // Clock, reset, bus
  input wire               sys_clk,
  input wire               nrst,
  input wire               sys_ce,
  input wire [`PCR_AW-1:0] reg_addr,
  input wire [`PCR_DW-1:0] reg_wdata,
  input wire               reg_wr,
  // Pins
  input wire               boot_pullup,
  input wire               user_out,
  input wire               user_tri,
  input wire               user_in_q,
  input wire               pad_i,
  input wire               pad_o_q,
  input wire               pad_oe_q,
  input wire               pull_up_q,
  input wire               pull_down_q,
  input wire               keep_o_q,
  input wire               keep_oe_q
);
  reg [2:0]  rdy_q;
  reg        done_q;
  reg [11:0] elem_q;
  reg [6:0]  inv_q;
  reg [3:0]  pad_q;
  wire       live = rdy_q[2];
  wire       wr = reg_wr & sys_ce;
  // Shadow config; rdy_q hides the two-flop reset release
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_q  <= 3'h0;
      done_q <= 1'b0;
      elem_q <= 12'h000;
      inv_q  <= 7'h00;
      pad_q  <= 4'h0;
    end else if (sys_ce) begin
      if (!live) rdy_q <= rdy_q + 3'h1;
      if (wr && reg_addr == `PCR_ADDR_CTRL) done_q <= done_q | reg_wdata[0];
      if (wr && reg_addr == `PCR_ADDR_ELEM) elem_q <= reg_wdata[11:0];
      if (wr && reg_addr == `PCR_ADDR_INV) inv_q <= reg_wdata[6:0];
      if (wr && reg_addr == `PCR_ADDR_PAD) pad_q <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_pre; live && !done_q; endsequence
  sequence s_cfg; live && $past(done_q); endsequence
  chk_pre_drv_off: assert property (s_pre |-> !pad_oe_q)
    else $error("driver on before done");
  chk_pre_pull_off: assert property (s_pre |-> !pull_down_q && !keep_oe_q)
    else $error("pull-down or keeper on before done");
  chk_boot_pull: assert property (s_pre |=> pull_up_q == $past(boot_pullup))
    else $error("pull-up not following mode pin");
  chk_post_pull: assert property (s_cfg |-> pull_up_q == $past(pad_q[0])
    && pull_down_q == $past(pad_q[1])) else $error("pull enables wrong");
  chk_keep_track: assert property (keep_oe_q |-> keep_o_q == $past(pad_i)
    && !pad_oe_q && $past(pad_q[2])) else $error("keeper wrong");
  chk_out_direct: assert property (s_cfg ##0 !$past(elem_q[7])
    |-> pad_o_q == ($past(user_out) ^ $past(inv_q[1]))) else $error("direct out wrong");
  chk_tri_direct: assert property (s_cfg ##0 !$past(elem_q[11])
    |-> pad_oe_q == !$past(user_tri)) else $error("direct enable wrong");
  chk_in_direct: assert property (s_cfg ##0 !$past(elem_q[3])
    |-> user_in_q == ($past(pad_i) ^ $past(inv_q[0]))) else $error("direct in wrong");
endmodule // pcr_pad_cell_monitor
bind pcr_pad_cell pcr_pad_cell_monitor u_mon (.sys_clk, .nrst, .sys_ce, .reg_addr,
  .reg_wdata, .reg_wr, .boot_pullup, .user_out, .user_tri, .user_in_q, .pad_i,
  .pad_o_q, .pad_oe_q, .pull_up_q, .pull_down_q, .keep_o_q, .keep_oe_q);

/* bench/pcr_pad_board.sv */
`timescale 1ns/100ps
module pcr_pad_board (
  // Pad cell drive
  input  wire sys_clk,
  input  wire pad_o_q,
  input  wire pad_oe_q,
  input  wire pull_up_q,
  input  wire pull_down_q,
  input  wire keep_o_q,
  input  wire keep_oe_q,
  // Board source and sensed level
  input  wire ext_en,
  input  wire ext_val,
  output wire pad_i
);
  reg float_q = 1'b0;
  // Floating pin wanders so a stale level never passes for a real one
  always @(posedge sys_clk) float_q <= ~float_q;
  // Strongest source wins, keeper weakest of all
  assign pad_i = pad_oe_q ? pad_o_q : ext_en ? ext_val : pull_up_q ? 1'b1 :
                 pull_down_q ? 1'b0 : keep_oe_q ? keep_o_q : float_q;
endmodule // pcr_pad_board

/* bench/pcr_pad_cell_bench.sv */
`timescale 1ns/100ps
`include "pcr_defines.vh"
module pcr_pad_cell_bench;
  reg         sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0, r, x;
  reg         boot_pullup = 1'b1, user_clk = 1'b0, user_sr = 1'b0, user_out = 1'b0;
  reg  [2:0]  user_ce = 3'h0;
  reg         user_tri = 1'b0, ext_en = 1'b0, ext_val = 1'b0, q, sys_ce = 1'b1;
  wire [31:0] reg_rdata_q;
  wire        user_in_q, pad_i, pad_o_q, pad_oe_q, pull_up_q, pull_down_q;
  wire        keep_o_q, keep_oe_q;
  integer     err_count = 0, checks_done = 0, i;
  always #4 sys_clk = ~sys_clk;
  pcr_pad_cell uut (.sys_clk, .nrst, .sys_ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .boot_pullup, .user_clk, .user_ce, .user_sr, .user_out,
    .user_tri, .user_in_q, .pad_i, .pad_o_q, .pad_oe_q, .pull_up_q, .pull_down_q,
    .keep_o_q, .keep_oe_q);
  pcr_pad_board u_board (.sys_clk, .pad_o_q, .pad_oe_q, .pull_up_q, .pull_down_q,
    .keep_o_q, .keep_oe_q, .ext_en, .ext_val, .pad_i);
  ////////////////////////////////////////////////////////////////////////
  // Set modes land on 1, reset modes on 0; sync ones wait for an edge
  function sr_q(input [1:0] m, input qo, input edg);
    sr_q = (m[1] | edg) ? ~m[0] : qo;
  endfunction
  task chk(input string nm, input [31:0] s, input [31:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd <= 1'b0;
    d = reg_rdata_q;
  endtask
  // One user clock edge, held high long enough to be seen
  task pulse;
    @(posedge sys_clk);
    user_clk <= 1'b1;
    tick(3);
    user_clk <= 1'b0;
    tick(2);
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    x = $urandom(32'h3f87);
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(6);
    chk("oe", pad_oe_q, 0);
    chk("pd_keep", {pull_down_q, keep_oe_q}, 0);
    chk("pu_boot", pull_up_q, 1);
    boot_pullup <= 1'b0;
    tick(2);
    chk("pu_boot", pull_up_q, 0);
    boot_pullup <= 1'b1;
    // Unmapped write leaves no trace; boot pull-up gives a known pad bit
    wr(8'h14, $urandom);
    for (i = 0; i < 6; i = i + 1) begin
      rd(8'h04 * i[7:0], r);
      chk("reset", r, (i == 4) ? 32'h8 : 32'h0);
    end
    user_tri <= 1'b1;
    wr(`PCR_ADDR_PAD, 32'h2);
    wr(`PCR_ADDR_CTRL, 32'h1);
    rd(`PCR_ADDR_CTRL, r);
    chk("done_rd", r, 1);
    tick(1);
    chk("rd_stand", reg_rdata_q, 0);
    chk("pulls", {pull_up_q, pull_down_q}, 1);
    wr(`PCR_ADDR_PAD, 32'h4);
    ext_en <= 1'b1;
    ext_val <= x[0];
    tick(3);
    ext_en <= 1'b0;
    tick(4);
    chk("keep", {keep_oe_q, pad_i}, {1'b1, x[0]});
    ext_en <= 1'b1;
    // Random inversion, drive and enable mix on the direct paths
    for (i = 0; i < 16; i = i + 1) begin
      x = $urandom;
      wr(`PCR_ADDR_INV, x[1:0]);
      ext_val <= x[2];
      user_out <= x[3];
      user_tri <= x[4];
      tick(3);
      chk("pad_o", pad_o_q, x[3] ^ x[1]);
      chk("pad_oe", pad_oe_q, !x[4]);
      chk("in", user_in_q, (x[4] ? x[2] : x[3] ^ x[1]) ^ x[0]);
    end
    wr(`PCR_ADDR_INV, 32'h0);
    user_tri <= 1'b0;
    wr(`PCR_ADDR_ELEM, 32'h80);
    q = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      x = $urandom;
      user_out <= x[0];
      user_ce <= {x[2], x[1], x[3]};
      pulse;
      if (x[1]) q = x[0];
      chk("ff", pad_o_q, q);
    end
    wr(`PCR_ADDR_ELEM, 32'h90);
    user_ce <= 3'h2;
    user_clk <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      user_out <= i[0];
      tick(3);
      chk("latch", pad_o_q, i[0]);
    end
    user_clk <= 1'b0;
    tick(2);
    user_out <= 1'b0;
    tick(3);
    chk("latch_hold", pad_o_q, 1);
    // Every set/reset mode, first without then with a clock edge
    for (i = 0; i < 4; i = i + 1) begin
      wr(`PCR_ADDR_ELEM, 32'h80 | (i << 5));
      user_out <= i[0];
      pulse;
      user_sr <= 1'b1;
      tick(3);
      chk("sr_idle", pad_o_q, sr_q(i[1:0], i[0], 1'b0));
      pulse;
      chk("sr_edge", pad_o_q, !i[0]);
      user_sr <= 1'b0;
    end
    // Inverted clock, set/reset and output clock enable: falling pin edge sets
    wr(`PCR_ADDR_ELEM, 32'h80);
    wr(`PCR_ADDR_INV, 32'h2C);
    rd(`PCR_ADDR_INV, r);
    chk("inv_rd", r, 32'h2C);
    chk("inv_hold", pad_o_q, 0);
    user_ce <= 3'h0;
    user_out <= 1'b0;
    pulse;
    chk("inv_set", pad_o_q, 1);
    wr(`PCR_ADDR_INV, 32'h0);
    user_tri <= 1'b1;
    user_ce <= 3'h1;
    wr(`PCR_ADDR_ELEM, 32'h8);
    // Delay holds the old pad level past a same-cycle clock edge
    for (i = 0; i < 2; i = i + 1) begin
      wr(`PCR_ADDR_PAD, i << 3);
      ext_val <= 1'b0;
      tick(5);
      ext_val <= 1'b1;
      user_clk <= 1'b1;
      tick(3);
      chk("in_delay", user_in_q, !i[0]);
      user_clk <= 1'b0;
      tick(2);
    end
    // Frozen block ignores a write; inputs stay steady meanwhile
    sys_ce <= 1'b0;
    wr(`PCR_ADDR_INV, 32'h2);
    sys_ce <= 1'b1;
    rd(`PCR_ADDR_INV, r);
    chk("freeze", r, 0);
    close_out;
  end
endmodule // pcr_pad_cell_bench
